// ===== rtl/obs_imm_gen.v
`timescale 1ns/10ps
`include "obs_regs.vh"
// immediate constant expander; purely combinational
module obs_imm_gen (
   input wire [7:0] imm_byte_i, // 8-bit payload
   input wire [4:0] imm_lsl_i, // left move count for plain form
   input wire [1:0] imm_form_i, // encoding form
   output reg [31:0] imm_val_o, // expanded constant
   output reg imm_carry_upd_o // carry takes bit 31
);
   reg [31:0] moved;
   // expand by form; only the moved byte form can touch carry
   always @*
   begin
      moved = {24'h000000, imm_byte_i} << imm_lsl_i;
      imm_carry_upd_o = 1'b0;
      case (imm_form_i)
         `OBS_IMM_ROT:
         begin
            imm_val_o = moved;
            imm_carry_upd_o = (moved > `OBS_IMM_LIMIT);
         end
         `OBS_IMM_B02: imm_val_o = {8'h00, imm_byte_i, 8'h00, imm_byte_i};
         `OBS_IMM_B13: imm_val_o = {imm_byte_i, 8'h00, imm_byte_i, 8'h00};
         `OBS_IMM_ALL: imm_val_o = {4{imm_byte_i}};
         default: imm_val_o = moved;
      endcase
   end
endmodule

// ===== rtl/obs_regs.vh
// Functional notes
// - second operand comes from encoded immediate or from shifted register
// - immediate accepts any 8-bit value moved left within 32 bits
// - immediate also gives byte-replicated forms 00XY00XY, XY00XY00, XYXYXYXY
// - flag-setting immediate above 255 from shifted byte sets carry to bit 31
// - shift amounts: right 1..32, left and rotate 1..31, extend one bit
// - omitted shift or left shift by zero passes source unchanged
// - shifted result feeds only the computation; source register stays unchanged
// - zero shift leaves carry; nonzero register shift updates carry
// - shifter serves standalone shifts and second operand forming
// - arithmetic right shift fills top n bits with source bit 31
// - arithmetic right shift carry is source bit n-1
// - arithmetic right shift by 32 or more gives bit 31 everywhere and carry
// - logical right shift fills top n bits with zero
// - logical right shift carry is source bit n-1
// - logical right shift 32+ gives zero; 33+ gives zero carry
// - left shift zeros low n bits, carry bit 32-n, 32+ zero, 33+ zero carry
// - rotate right carries low bits to top, carry bit n-1, mod 32
// - rotate with extend inserts carry at bit 31, carry takes bit 0
`ifndef OBS_REGS_VH
`define OBS_REGS_VH
// shift type encodings
`define OBS_SH_LSL 3'h0
`define OBS_SH_LSR 3'h1
`define OBS_SH_ASR 3'h2
`define OBS_SH_ROR 3'h3
`define OBS_SH_RRX 3'h4
// immediate encoding forms
`define OBS_IMM_ROT 2'h0
`define OBS_IMM_B02 2'h1
`define OBS_IMM_B13 2'h2
`define OBS_IMM_ALL 2'h3
// operand source select
`define OBS_SRC_REG 1'b0
`define OBS_SRC_IMM 1'b1
// widths
`define OBS_DW 32
`define OBS_AW 8
`define OBS_IMM_LIMIT 32'h000000FF
`define OBS_RST_DATA 32'h00000000
`endif

// ===== rtl/obs_shifter.v
`timescale 1ns/10ps
`include "obs_regs.vh"
// second-operand former and barrel shifter, one register stage
module obs_shifter (
   input wire clk_sys_i, // 100 MHz clock
   input wire rst_i, // async reset, active high
   input wire op_valid_i, // operation request this cycle
   input wire src_sel_i, // 0 register, 1 immediate
   input wire [31:0] shift_source_register_i, // register value to shift
   input wire [2:0] shift_type_i, // shift kind
   input wire [7:0] shift_amt_i, // shift length
   input wire [7:0] imm_byte_i, // immediate payload
   input wire [4:0] imm_lsl_i, // immediate left move count
   input wire [1:0] imm_form_i, // immediate form
   input wire flag_set_i, // instruction updates carry
   input wire carry_i, // current carry flag
   output reg [31:0] flexible_second_operand_o, // result word
   output reg carry_o, // carry for flag logic
   output reg carry_upd_o, // carry written by this op
   output reg result_valid_o // result valid pulse
);
   // expanded immediate and its carry request
   wire [31:0] imm_val;
   wire imm_cupd;
   // next values for the output registers
   reg [31:0] res_d;
   reg c_d;
   reg cupd_d;
   // working copies; wide is a 64-bit shift window, so the last bit
   // shifted out lands at one fixed position per kind: bit 32 left, bit 31 right
   reg [31:0] src;
   reg [7:0] n;
   reg [4:0] rn;
   reg [63:0] wide;

   // carry pick shared by the left, right and rotate kinds: the incoming flag is kept
   // unless this instruction writes carry, so the flag logic can always
   // write the output back without a select of its own
   function pick_carry;
      input upd;
      input new_c;
      input old_c;
      begin
         if (upd)
            pick_carry = new_c;
         else
            pick_carry = old_c;
      end
   endfunction

   // long-length decode shared by the linear kinds; the 8-bit length
   // reaches far past the word, and such lengths must not wrap
   function at_least;
      input [7:0] amt;
      input [7:0] limit;
      begin
         at_least = (amt >= limit);
      end
   endfunction

   // last bit rotated out; a whole-word turn reports bit 31
   function ror_carry;
      input [31:0] val;
      input [4:0] amt;
      begin
         if (amt == 5'h00)
            ror_carry = val[31];
         else
            ror_carry = val[amt - 5'h01];
      end
   endfunction

   // immediate forms are expanded beside the shifter, so both sources
   // reach the output select in the same cycle
   obs_imm_gen u_imm (
      .imm_byte_i(imm_byte_i),
      .imm_lsl_i(imm_lsl_i),
      .imm_form_i(imm_form_i),
      .imm_val_o(imm_val),
      .imm_carry_upd_o(imm_cupd)
   );

   // source operand is only read; result goes to a separate output
   always @*
   begin
      src = shift_source_register_i;
      n = shift_amt_i; // every 8-bit length is computed, not only the listed ones
      rn = n[4:0];
      wide = 64'h0000000000000000;
      res_d = src;
      c_d = carry_i; // default carry passes through
      cupd_d = 1'b0;
      // immediate source: the shift fields are ignored here
      if (src_sel_i == `OBS_SRC_IMM)
      begin
         res_d = imm_val;
         cupd_d = flag_set_i & imm_cupd;
         if (cupd_d)
            c_d = imm_val[31];
      end
      // one-bit extend ignores the length field entirely
      else if (shift_type_i == `OBS_SH_RRX)
      begin
         res_d = {carry_i, src[31:1]};
         cupd_d = flag_set_i;
         if (cupd_d)
            c_d = src[0];
      end
      // zero length is a plain pass for every kind but extend, carry included
      else if (n == 8'h00) // no shift, carry untouched
      begin
         res_d = src;
      end
      else
      begin
         cupd_d = flag_set_i; // nonzero shift updates carry
         case (shift_type_i)
            // left: low bits fill with zero; carry is the last bit out
            // lengths of 33 and up leave nothing of the source, carry zero
            `OBS_SH_LSL:
            begin
               if (at_least(n, 8'h21))
               begin
                  res_d = 32'h00000000;
                  c_d = pick_carry(cupd_d, 1'b0, carry_i);
               end
               else
               begin
                  wide = {32'h00000000, src} << n;
                  res_d = wide[31:0];
                  c_d = pick_carry(cupd_d, wide[32], carry_i); // bit 32-n
               end
            end
            // logical right: top bits fill with zero; the window keeps the
            // last bit out at bit 31 for every length up to 32
            `OBS_SH_LSR:
            begin
               if (at_least(n, 8'h21))
               begin
                  res_d = 32'h00000000;
                  c_d = pick_carry(cupd_d, 1'b0, carry_i);
               end
               else
               begin
                  wide = {src, 32'h00000000} >> n;
                  res_d = wide[63:32];
                  c_d = pick_carry(cupd_d, wide[31], carry_i); // bit n-1
               end
            end
            // arithmetic right: top bits copy the sign; from 32 on the
            // window is all sign, so the long case is decoded directly
            `OBS_SH_ASR:
            begin
               if (at_least(n, 8'h20))
               begin
                  res_d = {32{src[31]}};
                  c_d = pick_carry(cupd_d, src[31], carry_i);
               end
               else
               begin
                  wide = $signed({src, 32'h00000000}) >>> n;
                  res_d = wide[63:32];
                  c_d = pick_carry(cupd_d, wide[31], carry_i); // bit n-1
               end
            end
            `OBS_SH_ROR:
            begin
               // amounts reduce modulo 32; multiple of 32 keeps value
               wide = {src, src} >> rn;
               res_d = wide[31:0];
               c_d = pick_carry(cupd_d, ror_carry(src, rn), carry_i);
            end
            // codes 5 to 7 are unused: pass the source, write no carry
            default:
            begin
               res_d = src;
               cupd_d = 1'b0;
            end
         endcase
      end
   end

   // valid follows the request exactly one edge later; back to back is fine
   always @(posedge clk_sys_i or posedge rst_i)
   begin
      if (rst_i)
         result_valid_o <= 1'b0;
      else
         result_valid_o <= op_valid_i;
   end

   // register the result so data outputs come from flip-flops
   // one stage trades a cycle of latency for a clean boundary before
   // the flag logic; results hold between requests
   always @(posedge clk_sys_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         // reset shows no carry write, so the flag logic keeps its value
         flexible_second_operand_o <= `OBS_RST_DATA;
         carry_o <= 1'b0;
         carry_upd_o <= 1'b0;
      end
      else
      begin
         if (op_valid_i)
         begin
            flexible_second_operand_o <= res_d;
            carry_o <= c_d;
            carry_upd_o <= cupd_d;
         end
      end
   end
endmodule

// ===== testbench/obs_flag_model.sv
`timescale 1ns/10ps
module obs_flag_model (
   input wire clk_sys_i, // clock
   input wire rst_i, // reset
   input wire valid_i, // result pulse
   input wire upd_i, // carry written
   input wire carry_i, // new carry
   output reg carry_flag_o // flag fed back
);
   // flag moves only on an update, so kept carry round-trips
   always @(posedge clk_sys_i or posedge rst_i)
   begin
      if (rst_i)
         carry_flag_o <= 1'b0;
      else if (valid_i && upd_i)
         carry_flag_o <= carry_i;
   end
endmodule

// ===== testbench/obs_shifter_assertions.sv
`timescale 1ns/10ps
module obs_shifter_assertions (
   input wire clk_sys_i, // clock
   input wire rst_i, // reset
   input wire op_valid_i, // request
   input wire src_sel_i, // source
   input wire [31:0] shift_source_register_i, // value
   input wire [2:0] shift_type_i, // kind
   input wire [7:0] shift_amt_i, // length
   input wire flag_set_i, // flag op
   input wire carry_i, // carry in
   input wire [31:0] flexible_second_operand_o, // result
   input wire carry_o, // carry out
   input wire carry_upd_o, // carry written
   input wire result_valid_o // pulse
);
   default clocking cb @(posedge clk_sys_i);
   endclocking
   default disable iff (rst_i);
   // register requests; 32 and up must clear or fill the whole word
   wire rq = op_valid_i & ~src_sel_i;
   wire big = shift_amt_i > 8'h1F;
   a_result_pulse: assert property (op_valid_i |=> result_valid_o)
      else $error("no result");
   a_no_spurious: assert property (!op_valid_i |=> !result_valid_o)
      else $error("extra result");
   a_carry_kept: assert property (op_valid_i && !flag_set_i |=> !carry_upd_o && carry_o == $past(carry_i))
      else $error("carry moved");
   a_plain_pass: assert property (rq && shift_type_i == 3'h0 && shift_amt_i == 8'h00
      |=> flexible_second_operand_o == $past(shift_source_register_i) && !carry_upd_o) else $error("not passed");
   a_asr_fill: assert property (rq && shift_type_i == 3'h2 && big
      |=> flexible_second_operand_o == {32{$past(shift_source_register_i[31])}}) else $error("bad fill");
   a_lsr_clear: assert property (rq && shift_type_i == 3'h1 && big |=> flexible_second_operand_o == 32'h0)
      else $error("lsr not zero");
   a_lsl_clear: assert property (rq && shift_type_i == 3'h0 && big |=> flexible_second_operand_o == 32'h0)
      else $error("lsl not zero");
   a_rrx_insert: assert property (rq && shift_type_i == 3'h4
      |=> flexible_second_operand_o == {$past(carry_i), $past(shift_source_register_i[31:1])}) else $error("bad rrx");
endmodule
bind obs_shifter obs_shifter_assertions obs_shifter_assertions_i (.*);

// ===== testbench/obs_shifter_test.sv
`timescale 1ns/10ps
module obs_shifter_test;
   localparam [47:0] AMTS = 48'h00011F2021FF;
   reg clk_sys_i, rst_i, op_valid_i, src_sel_i, flag_set_i, pend;
   reg [31:0] shift_source_register_i, seed;
   reg [2:0] shift_type_i;
   reg [7:0] shift_amt_i, imm_byte_i;
   reg [4:0] imm_lsl_i;
   reg [1:0] imm_form_i;
   reg [33:0] exp_q;
   wire [31:0] flexible_second_operand_o;
   wire carry_i, carry_o, carry_upd_o, result_valid_o;
   integer miscompares, total_checks, cycles, i;
   obs_shifter obs_shifter_i (.*);
   obs_flag_model obs_flag_model_i (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .valid_i(result_valid_o),
      .upd_i(carry_upd_o), .carry_i(carry_o), .carry_flag_o(carry_i));
   // reference: {carry written, carry, operand}
   function [33:0] ref_out(input [2:0] ty, input [7:0] n, input [31:0] s, input ci);
      reg [31:0] r;
      reg c;
      reg u;
      begin
         case (ty)
            3'h0: {c, r} = {1'b0, s} << n;
            3'h1: {r, c} = {s, 1'b0} >> n;
            3'h2: {r, c} = $signed({s, 1'b0}) >>> n;
            3'h3: {r, c} = {s, s, s[31]} >> n[4:0];
            3'h4: {r, c} = {ci, s};
            default: {r, c} = {s, ci};
         endcase
         if (src_sel_i)
            r = imm_form_i == 2'h0 ? {24'h0, imm_byte_i} << imm_lsl_i : imm_form_i == 2'h1 ? {2{8'h00, imm_byte_i}}
               : imm_form_i == 2'h2 ? {2{imm_byte_i, 8'h00}} : {4{imm_byte_i}};
         if (src_sel_i)
            c = r[31];
         u = flag_set_i && (src_sel_i ? imm_form_i == 2'h0 && r > 32'hFF : ty == 3'h4 || ty < 3'h4 && n != 8'h00);
         ref_out = {u, u ? c : ci, r};
      end
   endfunction
   task check(input [33:0] seen, input [33:0] want);
      begin
         total_checks = total_checks + 1;
         if (seen !== want)
         begin
            miscompares = miscompares + 1;
            $display("unexpected at %0t: got %h want %h", $time, seen, want);
         end
      end
   endtask
   task end_sim;
      begin
         $display("checks %0d miscompares %0d", total_checks, miscompares);
         if (miscompares == 0 && total_checks > 0)
            $display("RESULT: PASS");
         else
            $display("RESULT: FAIL");
         $finish;
      end
   endtask
   task drive(input v, input sel, input [2:0] ty, input [7:0] n, input [1:0] fm, input fs);
      begin
         @(posedge clk_sys_i);
         {op_valid_i, src_sel_i, shift_type_i, shift_amt_i, imm_form_i, flag_set_i} <= {v, sel, ty, n, fm, fs};
         {shift_source_register_i, imm_byte_i, imm_lsl_i} <= {$random(seed), $random(seed)};
      end
   endtask
   initial
   begin
      clk_sys_i = 0;
      forever #5 clk_sys_i = ~clk_sys_i;
   end
   // results land one edge after the take; inputs read before this edge's updates
   always @(posedge clk_sys_i)
   begin
      cycles = cycles + 1;
      // under reset nothing is owed and every output reads zero; the
      // first edge is skipped since reset may only take hold on it
      if (rst_i)
      begin
         pend = 1'b0;
         if (cycles > 1)
         begin
            check({33'h0, result_valid_o}, 34'h0);
            check({carry_upd_o, carry_o, flexible_second_operand_o}, 34'h0);
         end
      end
      else
      begin
         check({33'h0, result_valid_o}, {33'h0, pend});
         if (pend)
            check({carry_upd_o, carry_o, flexible_second_operand_o}, exp_q);
         pend = op_valid_i; // above
         exp_q = ref_out(shift_type_i, shift_amt_i, shift_source_register_i, carry_i);
      end
      if (cycles == 3000)
      begin
         miscompares = miscompares + 1;
         end_sim;
      end
   end
   initial
   begin
      {miscompares, total_checks, cycles, pend, seed} = {96'h0, 1'b0, 32'hC3C5};
      {rst_i, op_valid_i, src_sel_i, flag_set_i, shift_source_register_i, shift_type_i} = {4'h8, 35'h0};
      {shift_amt_i, imm_byte_i, imm_lsl_i, imm_form_i} = 23'h0;
      repeat (16) @(posedge clk_sys_i);
      rst_i <= 0;
      // every kind at edge lengths, then each immediate form, then random mix
      for (i = 0; i < 72; i = i + 1)
         drive(1, 0, i / 12, AMTS[8 * (i % 6) +: 8], 0, (i / 6) % 2);
      for (i = 0; i < 8; i = i + 1)
         drive(1, 1, 0, 0, i % 4, i / 4);
      // mid-run reset right behind a request, then traffic from the second edge after release
      @(posedge clk_sys_i);
      {rst_i, op_valid_i} <= 2'h2;
      repeat (2) @(posedge clk_sys_i);
      rst_i <= 1'b0;
      repeat (600) drive($random(seed), $random(seed), $random(seed), $random(seed) % 40, $random(seed), $random(seed));
      drive(0, 0, 0, 0, 0, 0);
      repeat (2) @(posedge clk_sys_i);
      end_sim;
   end
endmodule
